// *** design/eve_pkg.sv ***
`default_nettype none
package eve_pkg;

	// ----------------------------------------------------------------
	// Vector table layout
	// ----------------------------------------------------------------
	localparam logic [31:0] RESET_BASE   = 32'hA0000000;
	localparam logic [7:0]  VEC_RESET_PC = 8'h00;
	localparam logic [7:0]  VEC_RESET_SP = 8'h01;
	localparam logic [7:0]  VEC_ILL_GEN  = 8'h04;
	localparam logic [7:0]  VEC_ILL_SLOT = 8'h06;
	localparam logic [7:0]  VEC_ADDR_ERR = 8'h09;
	localparam logic [7:0]  VEC_NMI      = 8'h0B;
	localparam logic [7:0]  VEC_UBREAK   = 8'h0C;
	localparam logic [7:0]  VEC_DBG_INT  = 8'h0D;

	// ----------------------------------------------------------------
	// Reset values and timing
	// ----------------------------------------------------------------
	localparam logic [31:0] VBR_RESET    = 32'h00000000;
	localparam logic [3:0]  MASK_RESET   = 4'hF;
	localparam int          CLK_MHZ      = 250;
	// Minimum low time of the reset pin, in clock periods
	localparam int          MIN_LOW_TCYC = 20;
	localparam logic [4:0]  MIN_LOW_CYC  = 5'(MIN_LOW_TCYC * CLK_MHZ / CLK_MHZ);

	// ----------------------------------------------------------------
	// Register map (byte offsets) and fields
	// ----------------------------------------------------------------
	localparam logic [7:0]  OFS_VBR      = 8'h00;
	localparam logic [7:0]  OFS_SR       = 8'h04;
	localparam logic [7:0]  OFS_RESET_CONTROL_STATUS_REG   = 8'h08;
	localparam logic [7:0]  OFS_PC       = 8'h0C;
	localparam logic [7:0]  OFS_SP       = 8'h10;
	localparam logic [7:0]  OFS_STATE    = 8'h14;
	localparam int          SR_MASK_LSB  = 4;
	localparam int          WATCHDOG_OVERFLOW_FLAG_BIT     = 0;
	localparam logic [1:0]  RESP_OKAY    = 2'h0;
	localparam logic [1:0]  RESP_SLVERR  = 2'h2;

	// ----------------------------------------------------------------
	// Types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		ST_HOLD      = 3'h0,
		ST_FETCH_PC  = 3'h1,
		ST_FETCH_SP  = 3'h2,
		ST_INIT      = 3'h3,
		ST_RUN       = 3'h4,
		ST_FETCH_EXC = 3'h5,
		ST_DBG_HOLD  = 3'h6
	} eve_state_t;

	typedef struct packed {
		logic       addr_err;
		logic       ill_gen;
		logic       ill_slot;
		logic       trap;
		logic       nmi;
		logic       ubreak;
		logic       dbg_int;
		logic       irq;
		logic [7:0] trap_vec;
		logic [7:0] irq_vec;
	} eve_exc_req_t;

	typedef struct packed {
		logic        req;
		logic [31:0] addr;
	} eve_fetch_t;

	function automatic logic [31:0] vec_addr(input logic [31:0] base,
	                                         input logic [7:0]  num);
		vec_addr = base + {22'h000000, num, 2'h0};
	endfunction

endpackage
`default_nettype wire

// *** design/eve_pin_sync.sv ***
`timescale 1ns/1ps
`default_nettype none
module eve_pin_sync (
	input  wire logic sys_clk,
	input  wire logic rst,
	input  wire logic pin_i,
	output logic      level_o
);
	logic s1_reg, s2_reg, s3_reg, lvl_reg;
	logic lvl_next;

	// A change counts only once the last two stages agree
	always_comb begin
		lvl_next = lvl_reg;
		if (s2_reg == s3_reg) begin
			lvl_next = s3_reg;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s1_reg  <= 1'b1;
			s2_reg  <= 1'b1;
			s3_reg  <= 1'b1;
			lvl_reg <= 1'b1;
		end else begin
			s1_reg  <= pin_i;
			s2_reg  <= s1_reg;
			s3_reg  <= s2_reg;
			lvl_reg <= lvl_next;
		end
	end

	assign level_o = lvl_reg;
endmodule
`default_nettype wire

// *** design/eve_exc_entry.sv ***
// What this block does
// - Each fixed exception source has its own distinct vector number and offset; all three resets share vectors 0 and 1.
// - Vector address comes from vector number; handler address fetched there.
// - Reset vector address is 0xA0000000 plus the table offset.
// - Other exceptions use vector base plus four times vector number.
// - Reset uses vector 0 for PC and vector 1 for SP.
// - Illegal instruction 4, illegal slot 6, address error 9.
// - NMI 11, user break 12, debug-port interrupt 13.
// - Any reset beats every other pending exception.
// - Power-on reset initialises CPU, interrupt unit, peripherals, pin logic.
// - While in reset state, CPU and peripheral registers stay initial.
// - Reset entry starts when pin rises after the required low time.
// - Initial PC is fetched first, initial SP afterwards.
// - Entry clears vector base and sets the four mask bits to ones.
// - Fetched values load PC and SP, then execution starts at PC.
// - Watchdog overflow with reset selected runs the same reset entry.
// - Pin reset wins over coincident watchdog reset; overflow flag cleared.
// - Debug-port reset assert initialises all and runs reset entry.
// - Debug reset entry starts only after assert then negate commands.
//
// The address map and the AXI4-Lite interface to the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none
module eve_exc_entry (
	input  wire logic                  sys_clk,
	input  wire logic                  rst,
	input  wire logic                  power_on_reset_pin,
	input  wire logic                  watchdog_overflow,
	input  wire logic                  watchdog_por_sel,
	input  wire logic                  dbg_reset_assert,
	input  wire logic                  dbg_reset_negate,
	input  wire eve_pkg::eve_exc_req_t exc_req,
	output eve_pkg::eve_fetch_t        fetch_o,
	input  wire logic                  fetch_ack,
	input  wire logic [31:0]           fetch_data,
	output logic [31:0]                pc_o,
	output logic [31:0]                sp_o,
	output logic                       core_run_o,
	output logic                       module_reset_o,
	output logic                       exc_ack_o,
	output logic [31:0]                handler_addr_o,
	output logic [7:0]                 handler_vec_o,
	input  wire logic [31:0]           s_axi_awaddr,
	input  wire logic                  s_axi_awvalid,
	output logic                       s_axi_awready,
	input  wire logic [31:0]           s_axi_wdata,
	input  wire logic [3:0]            s_axi_wstrb,
	input  wire logic                  s_axi_wvalid,
	output logic                       s_axi_wready,
	output logic [1:0]                 s_axi_bresp,
	output logic                       s_axi_bvalid,
	input  wire logic                  s_axi_bready,
	input  wire logic [31:0]           s_axi_araddr,
	input  wire logic                  s_axi_arvalid,
	output logic                       s_axi_arready,
	output logic [31:0]                s_axi_rdata,
	output logic [1:0]                 s_axi_rresp,
	output logic                       s_axi_rvalid,
	input  wire logic                  s_axi_rready
);
	// Local names for the sequencer states, so the case reads plainly
	localparam eve_pkg::eve_state_t ST_HOLD      = eve_pkg::ST_HOLD;
	localparam eve_pkg::eve_state_t ST_FETCH_PC  = eve_pkg::ST_FETCH_PC;
	localparam eve_pkg::eve_state_t ST_FETCH_SP  = eve_pkg::ST_FETCH_SP;
	localparam eve_pkg::eve_state_t ST_INIT      = eve_pkg::ST_INIT;
	localparam eve_pkg::eve_state_t ST_RUN       = eve_pkg::ST_RUN;
	localparam eve_pkg::eve_state_t ST_FETCH_EXC = eve_pkg::ST_FETCH_EXC;
	localparam eve_pkg::eve_state_t ST_DBG_HOLD  = eve_pkg::ST_DBG_HOLD;

	// ----------------------------------------------------------------
	// Pin synchroniser
	// ----------------------------------------------------------------
	logic pin_level;
	logic pin_low;

	eve_pin_sync u_pin_sync (
		.sys_clk (sys_clk),
		.rst     (rst),
		.pin_i   (power_on_reset_pin),
		.level_o (pin_level)
	);
	assign pin_low = ~pin_level;

	// ----------------------------------------------------------------
	// Register bus write strobes (from the bus group)
	// ----------------------------------------------------------------
	logic        wr_fire;
	logic [7:0]  wr_ofs;
	logic [31:0] wr_data;
	logic [3:0]  wr_strb;

	// ----------------------------------------------------------------
	// Reset entry and exception sequencer
	// ----------------------------------------------------------------
	eve_pkg::eve_state_t state_reg, state_next;
	logic [4:0]          low_cnt_reg, low_cnt_next;
	logic [31:0]         vbr_reg, vbr_next;
	logic [3:0]          mask_reg, mask_next;
	logic                watchdog_overflow_flag_reg, watchdog_overflow_flag_next;
	logic [31:0]         pc_reg, pc_next;
	logic [31:0]         sp_reg, sp_next;
	logic                run_reg, run_next;
	logic                mrst_reg, mrst_next;
	eve_pkg::eve_fetch_t fetch_reg, fetch_next;
	logic                eack_reg, eack_next;
	logic [31:0]         hadr_reg, hadr_next;
	logic [7:0]          hvec_reg, hvec_next;
	logic [7:0]          pend_vec;
	logic                pend_any;
	logic                wdt_fire;

	// Fixed order among non-reset sources; resets are handled below this, after the sequencer case
	always_comb begin
		pend_any = 1'b1;
		pend_vec = eve_pkg::VEC_ADDR_ERR;
		if (exc_req.addr_err) begin
			pend_vec = eve_pkg::VEC_ADDR_ERR;
		end else if (exc_req.ill_gen) begin
			pend_vec = eve_pkg::VEC_ILL_GEN;
		end else if (exc_req.ill_slot) begin
			pend_vec = eve_pkg::VEC_ILL_SLOT;
		end else if (exc_req.trap) begin
			pend_vec = exc_req.trap_vec;
		end else if (exc_req.nmi) begin
			pend_vec = eve_pkg::VEC_NMI;
		end else if (exc_req.ubreak) begin
			pend_vec = eve_pkg::VEC_UBREAK;
		end else if (exc_req.dbg_int) begin
			pend_vec = eve_pkg::VEC_DBG_INT;
		end else if (exc_req.irq) begin
			pend_vec = exc_req.irq_vec;
		end else begin
			pend_any = 1'b0;
		end
	end

	assign wdt_fire = watchdog_overflow & watchdog_por_sel;

	always_comb begin
		state_next   = state_reg;
		low_cnt_next = low_cnt_reg;
		vbr_next     = vbr_reg;
		mask_next    = mask_reg;
		watchdog_overflow_flag_next    = watchdog_overflow_flag_reg;
		pc_next      = pc_reg;
		sp_next      = sp_reg;
		run_next     = run_reg;
		fetch_next   = fetch_reg;
		eack_next    = 1'b0;
		hadr_next    = hadr_reg;
		hvec_next    = hvec_reg;
		mrst_next    = 1'b0;
		if (wr_fire && wr_ofs == eve_pkg::OFS_VBR) begin
			for (int i = 0; i < 4; i++) begin
				if (wr_strb[i]) begin
					vbr_next[i*8 +: 8] = wr_data[i*8 +: 8];
				end
			end
		end
		if (wr_fire && wr_ofs == eve_pkg::OFS_SR && wr_strb[0]) begin
			mask_next = wr_data[eve_pkg::SR_MASK_LSB +: 4];
		end
		// A write of 0 clears, and so does a pin reset coinciding with a watchdog reset; a watchdog reset in the same cycle as the write wins
		if (wr_fire && wr_ofs == eve_pkg::OFS_RESET_CONTROL_STATUS_REG && wr_strb[0] &&
		    !wr_data[eve_pkg::WATCHDOG_OVERFLOW_FLAG_BIT]) begin
			watchdog_overflow_flag_next = 1'b0;
		end
		unique case (state_reg)
			ST_HOLD: begin
				if (!pin_low && low_cnt_reg >= eve_pkg::MIN_LOW_CYC) begin
					state_next = ST_FETCH_PC;
				end
			end
			ST_FETCH_PC: begin
				if (fetch_ack) begin
					pc_next         = fetch_data;
					state_next      = ST_FETCH_SP;
					fetch_next.addr = eve_pkg::vec_addr(eve_pkg::RESET_BASE,
					                  eve_pkg::VEC_RESET_SP);
				end
			end
			ST_FETCH_SP: begin
				if (fetch_ack) begin
					sp_next        = fetch_data;
					fetch_next.req = 1'b0;
					state_next     = ST_INIT;
				end
			end
			ST_INIT: begin
				vbr_next   = eve_pkg::VBR_RESET;
				mask_next  = eve_pkg::MASK_RESET;
				run_next   = 1'b1;
				state_next = ST_RUN;
			end
			ST_RUN: begin
				// The requester drops its line only after the ack pulse
				if (pend_any && !eack_reg) begin
					hvec_next  = pend_vec;
					fetch_next = '{req: 1'b1,
					  addr: eve_pkg::vec_addr(vbr_reg, pend_vec)};
					state_next = ST_FETCH_EXC;
				end
			end
			ST_FETCH_EXC: begin
				if (fetch_ack) begin
					hadr_next      = fetch_data;
					eack_next      = 1'b1;
					fetch_next.req = 1'b0;
					state_next     = ST_RUN;
				end
			end
			ST_DBG_HOLD: begin
				if (dbg_reset_negate) begin
					state_next = ST_FETCH_PC;
				end
			end
			default: begin
				state_next = ST_HOLD;
			end
		endcase
		// Resets are taken last so they override any exception entry
		if (dbg_reset_assert && !pin_low) begin
			state_next = ST_DBG_HOLD;
		end
		if (wdt_fire && !pin_low) begin
			watchdog_overflow_flag_next  = 1'b1;
			state_next = ST_FETCH_PC;
		end
		if (pin_low) begin
			state_next = ST_HOLD;
			if (wdt_fire) begin
				watchdog_overflow_flag_next = 1'b0;
			end
		end
		if (pin_low) begin
			if (low_cnt_reg < eve_pkg::MIN_LOW_CYC) begin
				low_cnt_next = low_cnt_reg + 5'h01;
			end
		end else begin
			// A short pulse must not add up with a later one
			low_cnt_next = 5'h00;
		end
		// Initial values are held for as long as any reset state lasts
		if (state_next == ST_HOLD || state_next == ST_DBG_HOLD ||
		    (state_next == ST_FETCH_PC && state_reg != ST_FETCH_PC)) begin
			mrst_next  = 1'b1;
			run_next   = 1'b0;
			vbr_next   = eve_pkg::VBR_RESET;
			mask_next  = eve_pkg::MASK_RESET;
			pc_next    = 32'h00000000;
			sp_next    = 32'h00000000;
			eack_next  = 1'b0;
			fetch_next = '{req: 1'b0, addr: 32'h00000000};
		end
		if (state_next == ST_FETCH_PC && state_reg != ST_FETCH_PC) begin
			fetch_next = '{req: 1'b1,
			  addr: eve_pkg::vec_addr(eve_pkg::RESET_BASE,
			                          eve_pkg::VEC_RESET_PC)};
		end
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_reg   <= ST_HOLD;
			low_cnt_reg <= 5'h00;
			vbr_reg     <= eve_pkg::VBR_RESET;
			mask_reg    <= eve_pkg::MASK_RESET;
			watchdog_overflow_flag_reg    <= 1'b0;
			pc_reg      <= 32'h00000000;
			sp_reg      <= 32'h00000000;
			run_reg     <= 1'b0;
			mrst_reg    <= 1'b1;
			fetch_reg   <= '{req: 1'b0, addr: 32'h00000000};
			eack_reg    <= 1'b0;
			hadr_reg    <= 32'h00000000;
			hvec_reg    <= 8'h00;
		end else begin
			state_reg   <= state_next;
			low_cnt_reg <= low_cnt_next;
			vbr_reg     <= vbr_next;
			mask_reg    <= mask_next;
			watchdog_overflow_flag_reg    <= watchdog_overflow_flag_next;
			pc_reg      <= pc_next;
			sp_reg      <= sp_next;
			run_reg     <= run_next;
			mrst_reg    <= mrst_next;
			fetch_reg   <= fetch_next;
			eack_reg    <= eack_next;
			hadr_reg    <= hadr_next;
			hvec_reg    <= hvec_next;
		end
	end

	assign fetch_o        = fetch_reg;
	assign pc_o           = pc_reg;
	assign sp_o           = sp_reg;
	assign core_run_o     = run_reg;
	assign module_reset_o = mrst_reg;
	assign exc_ack_o      = eack_reg;
	assign handler_addr_o = hadr_reg;
	assign handler_vec_o  = hvec_reg;

	// ----------------------------------------------------------------
	// AXI4-Lite slave
	// ----------------------------------------------------------------
	logic        awh_reg, awh_next, wh_reg, wh_next;
	logic [7:0]  awa_reg, awa_next;
	logic [31:0] wd_reg, wd_next;
	logic [3:0]  ws_reg, ws_next;
	logic        awr_reg, awr_next, wr_reg, wr_next;
	logic        bv_reg, bv_next, arr_reg, arr_next, rv_reg, rv_next;
	logic [1:0]  br_reg, br_next, rr_reg, rr_next;
	logic [31:0] rd_reg, rd_next;

	function automatic logic mapped(input logic [7:0] ofs);
		mapped = ofs <= eve_pkg::OFS_STATE && ofs[1:0] == 2'h0;
	endfunction

	assign wr_fire = awh_reg & wh_reg & ~bv_reg;
	assign wr_ofs  = awa_reg;
	assign wr_data = wd_reg;
	assign wr_strb = ws_reg;

	always_comb begin
		awh_next = awh_reg;
		wh_next  = wh_reg;
		awa_next = awa_reg;
		wd_next  = wd_reg;
		ws_next  = ws_reg;
		bv_next  = bv_reg;
		br_next  = br_reg;
		arr_next = arr_reg;
		rv_next  = rv_reg;
		rr_next  = rr_reg;
		rd_next  = rd_reg;
		if (s_axi_awvalid && awr_reg) begin
			awh_next = 1'b1;
			awa_next = s_axi_awaddr[7:0];
		end
		if (s_axi_wvalid && wr_reg) begin
			wh_next = 1'b1;
			wd_next = s_axi_wdata;
			ws_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			awh_next = 1'b0;
			wh_next  = 1'b0;
			bv_next  = 1'b1;
			br_next  = mapped(awa_reg) ? eve_pkg::RESP_OKAY :
			           eve_pkg::RESP_SLVERR;
		end
		if (bv_reg && s_axi_bready) begin
			bv_next = 1'b0;
		end
		if (s_axi_arvalid && arr_reg) begin
			arr_next = 1'b0;
			rv_next  = 1'b1;
			rr_next  = mapped(s_axi_araddr[7:0]) ? eve_pkg::RESP_OKAY :
			           eve_pkg::RESP_SLVERR;
			unique case (s_axi_araddr[7:0])
				eve_pkg::OFS_VBR:    rd_next = vbr_reg;
				eve_pkg::OFS_SR:     rd_next = {24'h0, mask_reg, 4'h0};
				eve_pkg::OFS_RESET_CONTROL_STATUS_REG: rd_next = {31'h0, watchdog_overflow_flag_reg};
				eve_pkg::OFS_PC:     rd_next = pc_reg;
				eve_pkg::OFS_SP:     rd_next = sp_reg;
				eve_pkg::OFS_STATE:  rd_next = {20'h0, hvec_reg, run_reg,
				                                state_reg};
				default:             rd_next = 32'h00000000;
			endcase
		end
		if (rv_reg && s_axi_rready) begin
			rv_next  = 1'b0;
			arr_next = 1'b1;
		end
		awr_next = ~awh_next & ~bv_next;
		wr_next  = ~wh_next & ~bv_next;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			awh_reg <= 1'b0;
			wh_reg  <= 1'b0;
			awa_reg <= 8'h00;
			wd_reg  <= 32'h00000000;
			ws_reg  <= 4'h0;
			awr_reg <= 1'b1;
			wr_reg  <= 1'b1;
			bv_reg  <= 1'b0;
			br_reg  <= 2'h0;
			arr_reg <= 1'b1;
			rv_reg  <= 1'b0;
			rr_reg  <= 2'h0;
			rd_reg  <= 32'h00000000;
		end else begin
			awh_reg <= awh_next;
			wh_reg  <= wh_next;
			awa_reg <= awa_next;
			wd_reg  <= wd_next;
			ws_reg  <= ws_next;
			awr_reg <= awr_next;
			wr_reg  <= wr_next;
			bv_reg  <= bv_next;
			br_reg  <= br_next;
			arr_reg <= arr_next;
			rv_reg  <= rv_next;
			rr_reg  <= rr_next;
			rd_reg  <= rd_next;
		end
	end

	assign s_axi_awready = awr_reg;
	assign s_axi_wready  = wr_reg;
	assign s_axi_bvalid  = bv_reg;
	assign s_axi_bresp   = br_reg;
	assign s_axi_arready = arr_reg;
	assign s_axi_rvalid  = rv_reg;
	assign s_axi_rresp   = rr_reg;
	assign s_axi_rdata   = rd_reg;

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	AST_PC_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_FETCH_PC && fetch_reg.req |->
		fetch_reg.addr == 32'hA0000000)
		else $error("PC fetch not at reset base");
	AST_SP_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_FETCH_SP |-> fetch_reg.addr == 32'hA0000004)
		else $error("SP fetch not at reset base plus four");
	AST_PC_BEFORE_SP: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(state_reg == ST_FETCH_SP) |->
		$past(state_reg) == ST_FETCH_PC && $past(fetch_ack))
		else $error("SP fetched before PC");
	AST_INIT_VALUES: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_INIT && !pin_low && !wdt_fire && !dbg_reset_assert
		|=> vbr_reg == 32'h0 && mask_reg == 4'hF && run_reg)
		else $error("Entry did not set vector base and mask");
	AST_START_PC: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(run_reg) |-> pc_reg == $past(pc_reg, 2) && state_reg == ST_RUN)
		else $error("Run started without fetched PC");
	AST_EXC_ADDR: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_RUN && pend_any && !eack_reg && !pin_low &&
		!wdt_fire && !dbg_reset_assert |=> fetch_reg.req &&
		fetch_reg.addr == vbr_reg + {22'h0, $past(pend_vec), 2'h0})
		else $error("Exception vector address wrong");
	AST_HOLD_INIT: assert property (@(posedge sys_clk) disable iff (rst)
		pin_low [*2] |-> mrst_reg && !run_reg && !fetch_reg.req)
		else $error("Reset state not held");
	AST_PIN_WINS: assert property (@(posedge sys_clk) disable iff (rst)
		pin_low && wdt_fire |=> !watchdog_overflow_flag_reg && state_reg == ST_HOLD)
		else $error("Watchdog reset beat pin reset");
	AST_WDT_RESET: assert property (@(posedge sys_clk) disable iff (rst)
		!pin_low && wdt_fire |=> watchdog_overflow_flag_reg && state_reg == ST_FETCH_PC)
		else $error("Watchdog overflow did not start reset entry");
	AST_DBG_ORDER: assert property (@(posedge sys_clk) disable iff (rst)
		state_reg == ST_DBG_HOLD && !dbg_reset_negate && !pin_low &&
		!wdt_fire |=> state_reg == ST_DBG_HOLD)
		else $error("Debug reset entry before negate");
	AST_ALIGNED: assert property (@(posedge sys_clk) disable iff (rst)
		fetch_reg.req && state_reg != ST_FETCH_EXC |->
		fetch_reg.addr[1:0] == 2'h0)
		else $error("Unaligned vector fetch");
endmodule
`default_nettype wire

// *** sim/eve_vec_mem.sv ***
`timescale 1ns/1ps
`default_nettype none
module eve_vec_mem (
	input  wire logic                sys_clk,
	input  wire logic                rst,
	input  wire logic [3:0]          dly,
	input  wire eve_pkg::eve_fetch_t fetch_o,
	output logic                     fetch_ack,
	output logic [31:0]              fetch_data
);
	// Each word holds the inverse of its address, answered once cnt has counted up to dly
	logic [3:0] cnt;
	initial begin
		fetch_ack = 1'b0;
		fetch_data = 32'h00000000;
		cnt = 4'h0;
	end
	// Idle data toggles so a stale word never passes for an answer
	always @(posedge sys_clk) begin
		fetch_ack <= 1'b0;
		fetch_data <= ~fetch_data;
		if (rst || !fetch_o.req || fetch_ack) begin
			cnt <= 4'h0;
		end else if (cnt == dly) begin
			fetch_ack <= 1'b1;
			fetch_data <= ~fetch_o.addr;
			cnt <= 4'h0;
		end else begin
			cnt <= cnt + 4'h1;
		end
	end
endmodule
`default_nettype wire

// *** sim/exception_vector_and_reset_entry_test.sv ***
`timescale 1ns/1ps
`default_nettype none
module exception_vector_and_reset_entry_test;
	logic sys_clk, rst, power_on_reset_pin, watchdog_overflow;
	logic watchdog_por_sel, dbg_reset_assert, dbg_reset_negate;
	eve_pkg::eve_exc_req_t exc_req;
	eve_pkg::eve_fetch_t fetch_o;
	logic fetch_ack, core_run_o, module_reset_o, exc_ack_o;
	logic [31:0] fetch_data, pc_o, sp_o, handler_addr_o;
	logic [7:0] handler_vec_o;
	logic [31:0] s_axi_awaddr, s_axi_wdata, s_axi_araddr, s_axi_rdata;
	logic [3:0] s_axi_wstrb, dly;
	logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
	logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
	logic s_axi_rvalid, s_axi_rready;
	logic [1:0] s_axi_bresp, s_axi_rresp;
	int mismatches = 0;
	int n_checks = 0;
	logic [31:0] d;
	logic [1:0] r;

	eve_exc_entry u_eve_exc_entry (.*);
	eve_vec_mem u_eve_vec_mem (.*);

	initial begin
		sys_clk = 1'b0;
		forever #2 sys_clk = ~sys_clk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask

	// --------------------------------------------------------------
	// Bus and fetch helpers
	// --------------------------------------------------------------
	task automatic wr(input logic [31:0] a, input logic [31:0] v);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (s_axi_bvalid !== 1'b1);
		s_axi_bready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic rd(input logic [31:0] a);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge sys_clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			d = s_axi_rdata;
			r = s_axi_rresp;
		end while (s_axi_rvalid !== 1'b1);
		s_axi_rready <= 1'b0;
		@(posedge sys_clk);
	endtask

	task automatic fetch_at(input logic [31:0] a);
		int i;
		i = 0;
		while (fetch_o.req !== 1'b1 && i < 200) begin
			@(posedge sys_clk);
			i++;
		end
		chk(fetch_o.addr, a);
		do @(posedge sys_clk); while (fetch_ack !== 1'b1 && i++ < 400);
		@(posedge sys_clk);
	endtask

	task automatic reset_entry();
		int i;
		fetch_at(32'hA0000000);
		fetch_at(32'hA0000004);
		i = 0;
		while (core_run_o !== 1'b1 && i++ < 50) @(posedge sys_clk);
		chk(pc_o, 32'h5FFFFFFF);
		chk(sp_o, 32'h5FFFFFFB);
		rd(32'h00000000);
		chk(d, 32'h00000000);
		rd(32'h00000004);
		chk(d[7:4], 4'hF);
	endtask

	// --------------------------------------------------------------
	// Scenarios
	// --------------------------------------------------------------
	task automatic t_pin();
		wr(32'h00000000, 32'h00000040);
		wr(32'h00000004, 32'h00000000);
		power_on_reset_pin <= 1'b0;
		repeat (10) @(posedge sys_clk);
		power_on_reset_pin <= 1'b1;
		repeat (20) @(posedge sys_clk);
		chk(fetch_o.req, 1'b0);
		power_on_reset_pin <= 1'b0;
		repeat (25) @(posedge sys_clk);
		chk(module_reset_o, 1'b1);
		power_on_reset_pin <= 1'b1;
		reset_entry();
	endtask

	task automatic exc(input int k, input logic [7:0] v);
		int i;
		exc_req <= '0;
		case (k)
			0: exc_req.ill_gen <= 1'b1;
			1: exc_req.ill_slot <= 1'b1;
			2: exc_req.addr_err <= 1'b1;
			3: exc_req.nmi <= 1'b1;
			4: exc_req.ubreak <= 1'b1;
			default: exc_req.dbg_int <= 1'b1;
		endcase
		fetch_at(32'h00000200 + {22'h000000, v, 2'h0});
		i = 0;
		while (exc_ack_o !== 1'b1 && i++ < 20) @(posedge sys_clk);
		exc_req <= '0;
		chk(handler_vec_o, v);
		chk(handler_addr_o, ~(32'h00000200 + {22'h000000, v, 2'h0}));
		@(posedge sys_clk);
	endtask

	task automatic t_exc();
		dly <= 4'h0;
		wr(32'h00000000, 32'h00000200);
		exc(0, 8'h04);
		exc(1, 8'h06);
		exc(2, 8'h09);
		exc(3, 8'h0B);
		exc(4, 8'h0C);
		exc(5, 8'h0D);
		dly <= 4'h5;
	endtask

	task automatic t_wdog();
		exc_req.nmi <= 1'b1;
		watchdog_overflow <= 1'b1;
		@(posedge sys_clk);
		watchdog_overflow <= 1'b0;
		reset_entry();
		exc_req <= '0;
		rd(32'h00000008);
		chk(d[0], 1'b1);
	endtask

	task automatic t_dbg();
		dbg_reset_negate <= 1'b1;
		@(posedge sys_clk);
		dbg_reset_negate <= 1'b0;
		dbg_reset_assert <= 1'b1;
		@(posedge sys_clk);
		dbg_reset_assert <= 1'b0;
		repeat (6) @(posedge sys_clk);
		chk(module_reset_o, 1'b1);
		chk(fetch_o.req, 1'b0);
		dbg_reset_negate <= 1'b1;
		@(posedge sys_clk);
		dbg_reset_negate <= 1'b0;
		reset_entry();
		rd(32'h00000040);
		chk(r, eve_pkg::RESP_SLVERR);
		// Overflow flag is still set here; a coincident pin reset clears it
		power_on_reset_pin <= 1'b0;
		repeat (6) @(posedge sys_clk);
		watchdog_overflow <= 1'b1;
		@(posedge sys_clk);
		watchdog_overflow <= 1'b0;
		repeat (24) @(posedge sys_clk);
		power_on_reset_pin <= 1'b1;
		reset_entry();
		rd(32'h00000008);
		chk(d[0], 1'b0);
	endtask

	task automatic end_sim();
		$display("checks=%0d mismatches=%0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask

	initial begin
		repeat (20000) @(posedge sys_clk);
		mismatches++;
		end_sim();
	end

	initial begin
		{rst, power_on_reset_pin, watchdog_por_sel} = 3'b111;
		{watchdog_overflow, dbg_reset_assert, dbg_reset_negate} = 3'b000;
		{s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'b000;
		{s_axi_arvalid, s_axi_rready} = 2'b00;
		{s_axi_awaddr, s_axi_wdata, s_axi_araddr} = '0;
		s_axi_wstrb = 4'hF;
		exc_req = '0;
		dly = 4'h2;
		repeat (10) @(posedge sys_clk);
		rst <= 1'b0;
		@(posedge sys_clk);
		t_pin();
		t_exc();
		t_wdog();
		t_dbg();
		end_sim();
	end
endmodule
`default_nettype wire
